// file: efc_pkg.sv
// Contract
// (RULE_01) the enhanced feature control register lives at offset 0x09 and reads zero after reset.
// (RULE_02) bit 7 enables automatic transmit hold-off on cts or dsr, chosen by modem control bit 2.
// (RULE_03) bit 6 enables automatic receive flow control on the rts or dtr output.
// (RULE_04) with bit 5 set, a received second stop char goes into the fifo and sets status bit 4.
// (RULE_05) if rx software flow control compares the second stop char, a match is an xoff kept out of the fifo and raises xoff and special interrupts;
// the code raises the special interrupt only while bit 5 is set.
// (RULE_06) only while bit 4 is set may the guarded fields of enable, status, fifo, modem control, modem status, advanced special and sleep change.
// the code still sets guarded status bit 4 on a special char, and clears sleep once bit 4 is clear.
// (RULE_07) with auto transmit flow on and the selected input deasserted, the current character finishes and no new one starts until it reasserts.
package efc_pkg;
    localparam logic [3:0] off_interrupt_enable = 4'h1;
    localparam logic [3:0] off_advanced_special = 4'h2;
    localparam logic [3:0] off_fifo_control = 4'h3;
    localparam logic [3:0] off_modem_control = 4'h4;
    localparam logic [3:0] off_modem_status = 4'h6;
    localparam logic [3:0] off_efc = 4'h9;
    localparam logic [3:0] off_software_flow = 4'ha;
    localparam logic [3:0] off_second_stop_char = 4'hb;
    localparam logic [3:0] off_irq_status = 4'hc;
    localparam logic [3:0] off_irq_mask = 4'hd;
    localparam logic [3:0] off_sleep = 4'he;
    localparam logic [3:0] off_interrupt_status = 4'hf;
    localparam logic [7:0] efc_reset = 8'h00;
    localparam int efc_auto_cts_bit = 7;
    localparam int efc_auto_rts_bit = 6;
    localparam int efc_special_bit = 5;
    localparam int efc_unlock_bit = 4;
    localparam int mcr_select_bit = 2;
    localparam int isr_special_bit = 4;
    localparam logic [7:0] ier_guard = 8'he0;
    localparam logic [7:0] isr_guard = 8'h30;
    localparam logic [7:0] fcr_guard = 8'h30;
    localparam logic [7:0] mcr_guard = 8'hec;
    localparam logic [7:0] msr_guard = 8'h0c;
    localparam logic [7:0] asr_guard = 8'hff;
    localparam logic [1:0] rx_cmp_second = 2'h1;
    localparam logic [1:0] rx_cmp_both = 2'h3;
    localparam int irq_special = 0;
    localparam int irq_xoff = 1;
    localparam int irq_tx_done = 2;
    localparam int irq_width = 3;
endpackage : efc_pkg

// file: efc_rx_match.sv
`timescale 1ns/1ns
module efc_rx_match (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic [7:0] second_stop_char,
    input wire logic special_en,
    input wire logic [1:0] rx_compare,
    output logic fifo_write_q,
    output logic [7:0] fifo_char_q,
    output logic special_q,
    output logic xoff_q
);
    import efc_pkg::*;
    logic hit;
    logic flow_cmp;
    logic fifo_write_d;
    logic special_d;
    logic xoff_d;
    always_comb begin
        hit = rx_valid && (rx_char == second_stop_char);
        flow_cmp = (rx_compare == rx_cmp_second) || (rx_compare == rx_cmp_both);
        xoff_d = hit && flow_cmp; // see RULE_05
        fifo_write_d = rx_valid && !xoff_d; // see RULE_04
        special_d = hit && (special_en || flow_cmp) && special_en; // see RULE_04
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            fifo_write_q <= 1'b0;
            fifo_char_q <= 8'h00;
            special_q <= 1'b0;
            xoff_q <= 1'b0;
        end else begin
            fifo_write_q <= fifo_write_d;
            fifo_char_q <= rx_char;
            special_q <= special_d;
            xoff_q <= xoff_d;
        end
    end
    kept_out_a: assert property (@(posedge clk) disable iff (rst)
        (rx_valid && rx_char == second_stop_char && flow_cmp) |=> !fifo_write_q && xoff_q)
        else $error("flow xoff reached the fifo"); // see RULE_05
    special_fifo_a: assert property (@(posedge clk) disable iff (rst)
        (rx_valid && rx_char == second_stop_char && special_en && !flow_cmp) |=> fifo_write_q && special_q)
        else $error("special char not stored or flagged"); // see RULE_04
endmodule : efc_rx_match

// file: efc_tx_gate.sv
`timescale 1ns/1ns
module efc_tx_gate (
    input wire logic clk,
    input wire logic rst,
    input wire logic auto_en,
    input wire logic use_dsr,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic tx_req,
    input wire logic tx_busy,
    output logic tx_start_q,
    output logic held_q
);
    import efc_pkg::*;
    logic clear;
    logic start_d;
    logic held_d;
    always_comb begin
        clear = use_dsr ? !dsr_n : !cts_n; // see RULE_02
        held_d = auto_en && !clear; // see RULE_07
        start_d = tx_req && !tx_busy && !held_d && !tx_start_q;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_start_q <= 1'b0;
            held_q <= 1'b0;
        end else begin
            tx_start_q <= start_d;
            held_q <= held_d;
        end
    end
    hold_off_a: assert property (@(posedge clk) disable iff (rst)
        (auto_en && (use_dsr ? dsr_n : cts_n)) |=> !tx_start_q)
        else $error("character started while flow held"); // see RULE_07
endmodule : efc_tx_gate

// file: efc_top.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ns
module efc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic rx_above_trigger,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic tx_req,
    input wire logic tx_busy,
    input wire logic tx_done,
    output logic tx_start,
    output logic tx_held,
    output logic rts_n,
    output logic dtr_n,
    output logic fifo_write,
    output logic [7:0] fifo_char,
    output logic sleep_on,
    output logic irq
);
    import efc_pkg::*;
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] efc_q, efc_d;
    logic [7:0] ier_q, ier_d;
    logic [7:0] asr_q, asr_d;
    logic [7:0] fcr_q, fcr_d;
    logic [7:0] mcr_q, mcr_d;
    logic [7:0] msr_q, msr_d;
    logic [7:0] isr_q, isr_d;
    logic [3:0] sfc_q, sfc_d;
    logic [7:0] ssc_q, ssc_d;
    logic [irq_width-1:0] ist_q, ist_d;
    logic [irq_width-1:0] imask_q, imask_d;
    logic sleep_q, sleep_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic rts_q, rts_d;
    logic rtsn_q, rtsn_d;
    logic dtrn_q, dtrn_d;
    logic irq_q, irq_d;
    logic special, xoff;
    logic wr, rd;

    function automatic logic [7:0] guarded(input logic [7:0] old, input logic [7:0] nw,
                                           input logic [7:0] g, input logic unlock);
        guarded = unlock ? nw : ((old & g) | (nw & ~g)); // see RULE_06
    endfunction : guarded

    // ----------------------------------------
    // bus slave: one wait cycle per access
    // ----------------------------------------
    always_comb begin
        wr = avs_write && ack_q;
        rd = avs_read && !ack_q;
        ack_d = (avs_read || avs_write) && !ack_q;
        efc_d = efc_q;
        ier_d = ier_q;
        asr_d = asr_q;
        fcr_d = fcr_q;
        mcr_d = mcr_q;
        msr_d = msr_q;
        isr_d = isr_q;
        sfc_d = sfc_q;
        ssc_d = ssc_q;
        imask_d = imask_q;
        sleep_d = sleep_q;
        ist_d = ist_q;
        if (wr) begin
            unique case (avs_address)
                off_efc: efc_d = avs_writedata[7:0];
                off_interrupt_enable: ier_d = guarded(ier_q, avs_writedata[7:0], ier_guard, efc_q[efc_unlock_bit]);
                off_advanced_special: asr_d = guarded(asr_q, avs_writedata[7:0], asr_guard, efc_q[efc_unlock_bit]);
                off_fifo_control: fcr_d = guarded(fcr_q, avs_writedata[7:0], fcr_guard, efc_q[efc_unlock_bit]);
                off_modem_control: mcr_d = guarded(mcr_q, avs_writedata[7:0], mcr_guard, efc_q[efc_unlock_bit]);
                off_modem_status: msr_d = guarded(msr_q, avs_writedata[7:0], msr_guard, efc_q[efc_unlock_bit]);
                off_interrupt_status: isr_d = guarded(isr_q, avs_writedata[7:0], isr_guard, efc_q[efc_unlock_bit]);
                off_software_flow: sfc_d = avs_writedata[3:0];
                off_second_stop_char: ssc_d = avs_writedata[7:0];
                off_irq_mask: imask_d = avs_writedata[irq_width-1:0];
                off_sleep: if (efc_q[efc_unlock_bit]) begin
                    sleep_d = avs_writedata[0]; // see RULE_06
                end
                off_irq_status: ist_d = ist_q & ~avs_writedata[irq_width-1:0];
                default: ;
            endcase
        end
        if (!efc_q[efc_unlock_bit]) begin
            sleep_d = 1'b0; // see RULE_06
        end
        if (special) begin
            isr_d[isr_special_bit] = 1'b1; // see RULE_04
        end
        ist_d[irq_special] = ist_d[irq_special] | special;
        ist_d[irq_xoff] = ist_d[irq_xoff] | xoff;
        ist_d[irq_tx_done] = ist_d[irq_tx_done] | tx_done;
        rdata_d = 32'h0000_0000;
        if (rd) begin
            unique case (avs_address)
                off_efc: rdata_d = {24'h00_0000, efc_q};
                off_interrupt_enable: rdata_d = {24'h00_0000, ier_q};
                off_advanced_special: rdata_d = {24'h00_0000, asr_q};
                off_fifo_control: rdata_d = {24'h00_0000, fcr_q};
                off_modem_control: rdata_d = {24'h00_0000, mcr_q};
                off_modem_status: rdata_d = {24'h00_0000, msr_q};
                off_interrupt_status: rdata_d = {24'h00_0000, isr_q};
                off_software_flow: rdata_d = {28'h000_0000, sfc_q};
                off_second_stop_char: rdata_d = {24'h00_0000, ssc_q};
                off_irq_status: rdata_d = {29'h0000_0000, ist_q};
                off_irq_mask: rdata_d = {29'h0000_0000, imask_q};
                off_sleep: rdata_d = {31'h0000_0000, sleep_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        rts_d = !(efc_q[efc_auto_rts_bit] && rx_above_trigger); // see RULE_03
        rtsn_d = mcr_d[mcr_select_bit] ? 1'b1 : rts_d; // see RULE_03
        dtrn_d = mcr_d[mcr_select_bit] ? rts_d : 1'b1; // see RULE_03
        irq_d = |(ist_d & imask_d);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            efc_q <= efc_reset; // see RULE_01
            ier_q <= 8'h00;
            asr_q <= 8'h00;
            fcr_q <= 8'h00;
            mcr_q <= 8'h00;
            msr_q <= 8'h00;
            isr_q <= 8'h00;
            sfc_q <= 4'h0;
            ssc_q <= 8'h00;
            ist_q <= '0;
            imask_q <= '0;
            sleep_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            rts_q <= 1'b1;
            rtsn_q <= 1'b1;
            dtrn_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            efc_q <= efc_d;
            ier_q <= ier_d;
            asr_q <= asr_d;
            fcr_q <= fcr_d;
            mcr_q <= mcr_d;
            msr_q <= msr_d;
            isr_q <= isr_d;
            sfc_q <= sfc_d;
            ssc_q <= ssc_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            sleep_q <= sleep_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            rts_q <= rts_d;
            rtsn_q <= rtsn_d;
            dtrn_q <= dtrn_d;
            irq_q <= irq_d;
        end
    end

    always_comb begin
        avs_readdata = rdata_q;
        avs_waitrequest = !ack_q;
        sleep_on = sleep_q;
        irq = irq_q;
        rts_n = rtsn_q; // see RULE_03
        dtr_n = dtrn_q; // see RULE_03
    end

    // ----------------------------------------
    // receive match and transmit gate
    // ----------------------------------------
    efc_rx_match u_rx (
        .clk(clk),
        .rst(rst),
        .rx_valid(rx_valid),
        .rx_char(rx_char),
        .second_stop_char(ssc_q),
        .special_en(efc_q[efc_special_bit]),
        .rx_compare(sfc_q[1:0]),
        .fifo_write_q(fifo_write),
        .fifo_char_q(fifo_char),
        .special_q(special),
        .xoff_q(xoff)
    );
    efc_tx_gate u_tx (
        .clk(clk),
        .rst(rst),
        .auto_en(efc_q[efc_auto_cts_bit]),
        .use_dsr(mcr_q[mcr_select_bit]),
        .cts_n(cts_n),
        .dsr_n(dsr_n),
        .tx_req(tx_req),
        .tx_busy(tx_busy),
        .tx_start_q(tx_start),
        .held_q(tx_held)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    reset_zero_a: assert property (@(posedge clk) $past(rst) |-> efc_q == efc_reset)
        else $error("feature register not zero after reset"); // see RULE_01
    locked_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr && avs_address == off_modem_control && !efc_q[efc_unlock_bit]) |=> ((mcr_q ^ $past(mcr_q)) & mcr_guard) == 8'h00)
        else $error("guarded field changed while locked"); // see RULE_06
    sleep_lock_a: assert property (@(posedge clk) disable iff (rst)
        sleep_q |-> $past(efc_q[efc_unlock_bit]))
        else $error("sleep without unlock"); // see RULE_06
    special_flag_a: assert property (@(posedge clk) disable iff (rst)
        special |=> isr_q[isr_special_bit] && ist_q[irq_special])
        else $error("special detect not flagged"); // see RULE_04
    xoff_flag_a: assert property (@(posedge clk) disable iff (rst)
        xoff |=> ist_q[irq_xoff])
        else $error("xoff not flagged"); // see RULE_05
    rts_off_a: assert property (@(posedge clk) disable iff (rst)
        !efc_q[efc_auto_rts_bit] |=> rts_q)
        else $error("rts driven with auto flow off"); // see RULE_03
    answer_a: assert property (@(posedge clk) disable iff (rst)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("bus answer late");
    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        irq == |(ist_q & imask_q))
        else $error("interrupt out of step");
    special_c: cover property (@(posedge clk) disable iff (rst) special && !xoff);
    xoff_c: cover property (@(posedge clk) disable iff (rst) xoff);
    held_c: cover property (@(posedge clk) disable iff (rst) tx_held && tx_req);
    irq_c: cover property (@(posedge clk) disable iff (rst) irq);
endmodule : efc_top

// file: efc_peer.sv
`timescale 1ns/1ns
// ----------------------------------------
// remote peer: modem lines, rx chars, tx shifter
// ----------------------------------------
module efc_peer (
    input wire logic clk,
    input wire logic rst,
    input wire logic send,
    input wire logic [7:0] send_char,
    input wire logic stop_cts,
    input wire logic stop_dsr,
    input wire logic tx_start,
    output logic cts_n,
    output logic dsr_n,
    output logic rx_valid,
    output logic [7:0] rx_char,
    output logic tx_busy,
    output logic tx_done
);
    logic [2:0] bits_q;
    always_ff @(posedge clk) begin
        cts_n <= stop_cts;
        dsr_n <= stop_dsr;
        rx_valid <= send && !rst;
        // idle data line toggles so no stale char is seen
        rx_char <= send ? send_char : ~rx_char;
        tx_done <= tx_busy && bits_q == 3'h1;
        if (rst) begin
            rx_char <= 8'ha5;
            tx_busy <= 1'b0;
            bits_q <= 3'h0;
        end else if (tx_start) begin
            tx_busy <= 1'b1;
            bits_q <= 3'h6;
        end else if (bits_q != 3'h0) begin
            bits_q <= bits_q - 3'h1;
            tx_busy <= bits_q != 3'h1;
        end
    end
endmodule : efc_peer

// file: tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    import efc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, rx_valid, cts_n, dsr_n, tx_busy, tx_done, tx_start, tx_held;
    logic rts_n, dtr_n, fifo_write, sleep_on, irq;
    logic [7:0] rx_char, fifo_char, rd;
    logic rx_above_trigger = 1'b0, tx_req = 1'b0, send = 1'b0, stop_cts = 1'b0, stop_dsr = 1'b0;
    logic [7:0] send_char = 8'h00;
    int error_cnt = 0;
    int check_count = 0;
    int starts = 0;
    always #50 clk = ~clk;
    always @(negedge clk) if (tx_start === 1'b1) starts++;
    efc_top DUT (.*);
    efc_peer peer (.*);
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            report_and_stop();
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rd_expect(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK("register", e, rd)
    endtask : rd_expect
    task automatic rx_send(input logic [7:0] c, input logic fifo_exp);
        send_char <= c;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        cyc(2);
        `CHK("fifo_write", fifo_exp, fifo_write)
        if (fifo_exp) `CHK("fifo_char", c, fifo_char)
        cyc(2);
    endtask : rx_send
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        `CHK("rts_n", 1'b1, rts_n & dtr_n)
        rd_expect(off_efc, efc_reset);
        rd_expect(4'h5, 8'h00);
        `CHK("irq", 1'b0, irq)
        $display("test reset done");
    endtask : t_reset
    task automatic t_lock();
        logic [3:0] a[3] = '{off_interrupt_enable, off_modem_control, off_advanced_special};
        logic [7:0] g[3] = '{ier_guard, mcr_guard, asr_guard};
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, a[i], 8'hff);
            rd_expect(a[i], ~g[i]);
        end
        bus(1'b1, off_sleep, 8'h01);
        `CHK("sleep_on", 1'b0, sleep_on)
        bus(1'b1, off_efc, 8'h10);
        rd_expect(off_efc, 8'h10);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, a[i], 8'hff);
            rd_expect(a[i], 8'hff);
            bus(1'b1, a[i], 8'h00);
        end
        bus(1'b1, off_sleep, 8'h01);
        `CHK("sleep_on", 1'b1, sleep_on)
        bus(1'b1, off_efc, 8'h00);
        cyc(1);
        `CHK("sleep_on", 1'b0, sleep_on)
        $display("test lock done");
    endtask : t_lock
    task automatic t_rx();
        logic [1:0] codes[2] = '{rx_cmp_second, rx_cmp_both};
        bus(1'b1, off_second_stop_char, 8'h5a);
        bus(1'b1, off_irq_mask, 8'h00);
        rx_send(8'h5a, 1'b1);
        rd_expect(off_irq_status, 8'h00);
        bus(1'b1, off_efc, 8'h20);
        rx_send(8'h5b, 1'b1);
        rd_expect(off_irq_status, 8'h00);
        rx_send(8'h5a, 1'b1);
        bus(1'b0, off_interrupt_status, 8'h00);
        `CHK("special status", 1'b1, rd[isr_special_bit])
        rd_expect(off_irq_status, 8'h01);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, off_irq_mask, 8'h07);
        cyc(1);
        `CHK("irq", 1'b1, irq)
        bus(1'b1, off_irq_status, 8'h01);
        cyc(1);
        `CHK("irq cleared", 1'b0, irq)
        rd_expect(off_irq_status, 8'h00);
        bus(1'b1, off_irq_mask, 8'h00);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, off_software_flow, {6'h0, codes[i]});
            rx_send(8'h5a, 1'b0);
            rd_expect(off_irq_status, 8'h03);
            bus(1'b1, off_irq_status, 8'h03);
        end
        bus(1'b1, off_software_flow, 8'h00);
        bus(1'b1, off_efc, 8'h00);
        $display("test rx done");
    endtask : t_rx
    task automatic t_tx(input logic sel);
        int s;
        bus(1'b1, off_efc, 8'h90);
        bus(1'b1, off_modem_control, {5'h0, sel, 2'h0});
        stop_cts <= sel;
        stop_dsr <= !sel;
        tx_req <= 1'b1;
        s = starts;
        cyc(20);
        `CHK("tx other line", 1'b1, starts > s)
        stop_cts <= 1'b1;
        stop_dsr <= 1'b1;
        cyc(12);
        s = starts;
        cyc(20);
        `CHK("tx halted", 1'b1, starts == s)
        `CHK("tx_held", 1'b1, tx_held)
        stop_cts <= sel;
        stop_dsr <= !sel;
        cyc(6);
        `CHK("tx resumed", 1'b1, starts > s)
        bus(1'b1, off_efc, 8'h10);
        stop_cts <= 1'b1;
        stop_dsr <= 1'b1;
        s = starts;
        cyc(20);
        `CHK("tx auto off", 1'b1, starts > s)
        tx_req <= 1'b0;
        stop_cts <= 1'b0;
        stop_dsr <= 1'b0;
        bus(1'b1, off_modem_control, 8'h00);
        bus(1'b1, off_efc, 8'h00);
        cyc(10);
        $display("test tx done");
    endtask : t_tx
    task automatic t_rts();
        bus(1'b1, off_efc, 8'h50);
        for (int sel = 0; sel < 2; sel++) begin
            bus(1'b1, off_modem_control, sel[0] ? 8'h04 : 8'h00);
            rx_above_trigger <= 1'b1;
            cyc(3);
            `CHK("rts_n", sel[0], rts_n)
            `CHK("dtr_n", !sel[0], dtr_n)
            rx_above_trigger <= 1'b0;
            cyc(3);
            `CHK("rts_n dtr_n", 1'b1, rts_n & dtr_n)
        end
        bus(1'b1, off_efc, 8'h10);
        rx_above_trigger <= 1'b1;
        cyc(3);
        `CHK("rts_n dtr_n off", 1'b1, rts_n & dtr_n)
        rx_above_trigger <= 1'b0;
        bus(1'b1, off_modem_control, 8'h00);
        bus(1'b1, off_efc, 8'h00);
        $display("test rts done");
    endtask : t_rts
    initial begin
        cyc(16);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_lock();
        t_rx();
        t_tx(1'b0);
        t_tx(1'b1);
        t_rts();
        report_and_stop();
    end
endmodule : tb_top
